// file: adc_cfg_pkg.sv
// Shared constants, types and decode helpers for the converter configuration block.
`default_nettype none
package adc_cfg_pkg;
    // Wishbone byte address width; register index sits in bits [9:2].
    localparam int unsigned WB_ADR_W = 10;
    localparam int unsigned WB_DAT_W = 32;
    localparam int unsigned IDX_LSB = 2;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_ACC_CFG = 8'hBA;
    localparam logic [7:0] IDX_CONV_CFG = 8'hBC;
    localparam logic [7:0] IDX_RES_LO = 8'hBD;
    localparam logic [7:0] IDX_RES_HI = 8'hBE;
    // Reset values.
    localparam logic [7:0] CONV_CFG_RST = 8'hF8;
    localparam logic [7:0] ACC_CFG_RST = 8'h00;
    // Converter configuration fields.
    localparam int unsigned CF_SC_HI = 7;
    localparam int unsigned CF_SC_LO = 3;
    localparam int unsigned CF_8BIT = 2;
    localparam int unsigned CF_TM = 1;
    localparam int unsigned CF_GAIN = 0;
    // Accumulator configuration fields.
    localparam int unsigned AC_AE = 6;
    localparam int unsigned AC_SJ_HI = 5;
    localparam int unsigned AC_SJ_LO = 3;
    localparam int unsigned AC_RPT_HI = 2;
    localparam int unsigned AC_RPT_LO = 0;
    // Conversion timing in conversion-clock cycles.
    localparam logic [3:0] TRACK_CLKS = 4'h3;
    localparam logic [3:0] BITS_TEN = 4'hA;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    // Low-power oscillator rate, kept for reference by software divider math.
    localparam int unsigned LP_OSC_FREQ_MHZ = 20;
    // Result formatting.
    localparam logic [2:0] SJ_LEFT = 3'h4;
    localparam int unsigned LEFT_SHIFT = 6;
    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONVERT = 2'b10
    } seq_state_e;
    // Repeat code to number of conversions; reserved codes fall back to one.
    function automatic logic [6:0] rpt_to_count(input logic [2:0] code);
        unique case (code)
            3'h1: rpt_to_count = 7'h04;
            3'h2: rpt_to_count = 7'h08;
            3'h3: rpt_to_count = 7'h10;
            3'h4: rpt_to_count = 7'h20;
            3'h5: rpt_to_count = 7'h40;
            default: rpt_to_count = 7'h01;
        endcase
    endfunction
endpackage
`default_nettype wire

// file: conv_link_if.sv
// Internal carrier between the configuration block, its divider and its result formatter.
`timescale 1ns/1ps
`default_nettype none
interface conv_link_if;
    logic src_tick; // One divider source edge this cycle.
    logic restart; // Holds the divider at phase zero.
    logic [4:0] divider; // Divide by this value plus one.
    logic sar_tick; // One conversion-clock cycle elapsed.
    logic [15:0] acc; // Raw accumulator.
    logic [2:0] fmt; // Shift and justify code.
    logic eight_bit; // Eight-bit resolution selected.
    logic [15:0] formatted; // Value as software reads it.
    modport div_mp (input src_tick, input restart, input divider, output sar_tick);
    modport fmt_mp (input acc, input fmt, input eight_bit, output formatted);
    modport ctl_mp (output src_tick, output restart, output divider, input sar_tick,
                    output acc, output fmt, output eight_bit, input formatted);
endinterface
`default_nettype wire

// file: sar_clock_divider.sv
// Conversion clock divider counting source edges.
`timescale 1ns/1ps
`default_nettype none
module sar_clock_divider (
    input wire logic clk_i,
    input wire logic rst_i,
    conv_link_if.div_mp link
);
    import adc_cfg_pkg::*;

    // Whole state of the divider.
    typedef struct packed {
        logic [4:0] cnt;
        logic tick;
    } div_s;

    div_s q;
    div_s d;

    assign link.sar_tick = q.tick;

    // A tick is issued on the source edge that completes divider+1 edges.
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (link.restart) begin
            d.cnt = '0;
        end else if (link.src_tick) begin
            if (q.cnt == link.divider) begin // RULE1
                d.cnt = '0;
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + 5'h01;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // A tick always follows a source edge seen with the count at the divider value.
    property p_tick_cause;
        @(posedge clk_i) disable iff (rst_i)
        link.sar_tick |-> $past(link.src_tick) && ($past(q.cnt) == $past(link.divider));
    endproperty
    a_tick_cause: assert property (p_tick_cause) else $error("Conversion tick without full divide."); // RULE1
endmodule
`default_nettype wire

// file: result_formatter.sv
// Read-path shift, justification and eight-bit masking of the accumulator.
`timescale 1ns/1ps
`default_nettype none
module result_formatter (
    conv_link_if.fmt_mp link
);
    import adc_cfg_pkg::*;

    // The accumulator itself is never shifted; only the view software reads is.
    always_comb begin
        if (link.fmt == SJ_LEFT) begin // RULE11
            link.formatted = link.acc << LEFT_SHIFT;
        end else if (!link.fmt[2]) begin // RULE11
            link.formatted = link.acc >> link.fmt[1:0];
        end else begin
            link.formatted = link.acc;
        end
        if (link.eight_bit) begin // RULE14
            link.formatted[7:0] = 8'h00;
        end
    end
endmodule
`default_nettype wire

// file: adc_config_and_accumulator.sv
// Converter configuration, conversion sequencing and result accumulator with a Wishbone slave.
//
// Operation
// RULE1: Conversion clock is source over divider plus one.
// RULE2: Source is system clock, or oscillator in burst.
// RULE3: Software rounds divider setting upward.
// RULE4: Resolution bit picks ten or eight bits.
// RULE5: Normal track: convert straight after start.
// RULE6: Delayed track: three conversion clocks first.
// RULE7: Gain bit picks half or unity gain.
// RULE8: Accumulate bit sums results outside burst mode.
// RULE9: Software zeroes result bytes to restart sum.
// RULE10: Accumulate bit is write-only, reads zero.
// RULE11: Format field shifts or left-justifies reads.
// RULE12: Burst repeat field sets conversions per start.
// RULE13: Software keeps repeat zero outside burst mode.
// RULE14: Eight-bit mode zeroes low bits, low byte.
// RULE15: Burst delayed track precedes every conversion.
// RULE16: Low result byte write loads accumulator directly.
// RULE17: Burst enable picks clock source and repeats.
// RULE18: Accumulator stores raw sums; format on read.
// RULE19: Reserved configuration top bit reads zero.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adc_config_and_accumulator (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [adc_cfg_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [adc_cfg_pkg::WB_DAT_W-1:0] wb_dat_i,
    output logic [adc_cfg_pkg::WB_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic burst_mode_enable_i,
    input wire logic adc_enable_i,
    input wire logic conv_start_i,
    input wire logic lp_osc_i,
    input wire logic [9:0] conv_result_i,
    output logic conversion_clock_o,
    output logic tracking_o,
    output logic converting_o,
    output logic eight_bit_select_o,
    output logic gain_select_o,
    output logic conv_done_o,
    output logic burst_done_o
);
    import adc_cfg_pkg::*;

    // Whole state of the block in one record.
    typedef struct packed {
        logic [7:0] conv_cfg; // Divider, resolution, track mode and gain.
        logic accum_en; // Write-only accumulate enable.
        logic [2:0] sj_fmt; // Shift and justify code.
        logic [2:0] rpt; // Burst repeat code.
        logic [15:0] acc; // Raw sixteen-bit accumulator.
        seq_state_e st; // Conversion sequencer state.
        logic [3:0] step_cnt; // Conversion clocks left in this phase.
        logic [6:0] reps_left; // Conversions left in this start.
        logic in_burst; // Burst mode latched at the start event.
        logic ack; // Wishbone acknowledge.
        logic [31:0] rdata; // Registered read data.
        logic osc_meta; // First synchroniser stage of the oscillator.
        logic osc_sync; // Second synchroniser stage.
        logic osc_prev; // Previous synchronised level for edge detect.
        logic conv_done; // One conversion finished.
        logic burst_done; // Whole start sequence finished.
    } state_s;

    localparam state_s STATE_RST = '{conv_cfg: CONV_CFG_RST, st: ST_IDLE, default: '0};

    state_s q;
    state_s d;

    conv_link_if link ();

    // Decoding of the register index, shared by the read and write paths.
    function automatic logic reg_hit(input logic [WB_ADR_W-1:0] adr, input logic [7:0] idx);
        reg_hit = (adr[WB_ADR_W-1:IDX_LSB] == idx);
    endfunction

    // Conversion clocks needed for the bits of one conversion.
    function automatic logic [3:0] bit_clocks(input logic eight);
        bit_clocks = eight ? BITS_EIGHT : BITS_TEN;
    endfunction

    logic req; // New bus request not yet acknowledged.
    logic wr; // Write taking effect at this edge.
    logic burst_sel; // Burst mode as seen this cycle.
    logic osc_rise; // Rising edge of the synchronised oscillator.
    logic delayed; // Delayed track mode selected.
    logic eight; // Eight-bit mode selected.
    logic [15:0] sample; // Finished conversion, widened.

    // The divider and the formatter sit on the internal carrier.
    sar_clock_divider u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .link(link.div_mp)
    );

    result_formatter u_fmt (
        .link(link.fmt_mp)
    );

    // Oscillator edges only count in burst; otherwise every system clock counts.
    assign osc_rise = q.osc_sync & ~q.osc_prev;
    assign burst_sel = burst_mode_enable_i;
    assign link.src_tick = burst_sel ? osc_rise : 1'b1; // RULE2 RULE17
    // Holding the divider while idle makes every sequence start on a fresh phase.
    assign link.restart = (q.st == ST_IDLE);
    assign link.divider = q.conv_cfg[CF_SC_HI:CF_SC_LO]; // RULE1
    assign link.acc = q.acc;
    assign link.fmt = q.sj_fmt;
    assign link.eight_bit = q.conv_cfg[CF_8BIT];

    assign delayed = q.conv_cfg[CF_TM];
    assign eight = q.conv_cfg[CF_8BIT];
    // Eight-bit conversions never produce the two lowest bits.
    assign sample = eight ? {6'h00, conv_result_i[9:2], 2'b00} : {6'h00, conv_result_i}; // RULE14

    // Bus handshake: one request cycle, then a registered acknowledge.
    assign req = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wr = q.ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];

    // Outputs come straight from flip-flops or the divider register, except the two state flags decoded from the state.
    assign wb_dat_o = q.rdata;
    assign wb_ack_o = q.ack;
    assign conversion_clock_o = link.sar_tick;
    assign tracking_o = (q.st != ST_CONVERT);
    assign converting_o = (q.st == ST_CONVERT);
    assign eight_bit_select_o = eight; // RULE4
    assign gain_select_o = q.conv_cfg[CF_GAIN]; // RULE7
    assign conv_done_o = q.conv_done;
    assign burst_done_o = q.burst_done;

    // Next-state logic for bus, configuration, accumulator and sequencer.
    always_comb begin
        d = q;
        d.osc_meta = lp_osc_i;
        d.osc_sync = q.osc_meta;
        d.osc_prev = q.osc_sync;
        d.conv_done = 1'b0;
        d.burst_done = 1'b0;
        d.ack = req;

        // Read data is captured with the request; unmapped indices read zero.
        if (req) begin
            d.rdata = '0;
            if (reg_hit(wb_adr_i, IDX_CONV_CFG)) begin
                d.rdata[7:0] = q.conv_cfg;
            end else if (reg_hit(wb_adr_i, IDX_ACC_CFG)) begin
                // The accumulate bit and the reserved bit always read low.
                d.rdata[7:0] = {1'b0, 1'b0, q.sj_fmt, q.rpt}; // RULE10 RULE19
            end else if (reg_hit(wb_adr_i, IDX_RES_LO)) begin
                d.rdata[7:0] = link.formatted[7:0]; // RULE18
            end else if (reg_hit(wb_adr_i, IDX_RES_HI)) begin
                d.rdata[7:0] = link.formatted[15:8]; // RULE18
            end
        end

        // Writes take effect at the acknowledge edge; lane zero carries the byte.
        if (wr) begin
            if (reg_hit(wb_adr_i, IDX_CONV_CFG)) begin
                d.conv_cfg = wb_dat_i[7:0];
            end else if (reg_hit(wb_adr_i, IDX_ACC_CFG)) begin
                // Bit seven is dropped so the reserved position stays zero.
                d.accum_en = wb_dat_i[AC_AE];
                d.sj_fmt = wb_dat_i[AC_SJ_HI:AC_SJ_LO];
                d.rpt = wb_dat_i[AC_RPT_HI:AC_RPT_LO];
            end else if (reg_hit(wb_adr_i, IDX_RES_LO)) begin
                d.acc[7:0] = wb_dat_i[7:0]; // RULE16
            end else if (reg_hit(wb_adr_i, IDX_RES_HI)) begin
                d.acc[15:8] = wb_dat_i[7:0];
            end
        end

        // Sequencer; a finished conversion overrides a result write in the same cycle.
        unique case (q.st)
            ST_IDLE: begin
                // Outside burst the converter must be enabled; in burst it powers itself.
                if (conv_start_i && (adc_enable_i || burst_sel)) begin
                    d.in_burst = burst_sel;
                    d.reps_left = burst_sel ? rpt_to_count(q.rpt) : 7'h01; // RULE12 RULE17
                    if (burst_sel) begin
                        d.acc = '0;
                    end
                    if (delayed) begin
                        d.st = ST_TRACK; // RULE6
                        d.step_cnt = TRACK_CLKS;
                    end else begin
                        d.st = ST_CONVERT; // RULE5
                        d.step_cnt = bit_clocks(eight);
                    end
                end
            end
            ST_TRACK: begin
                // Sample capacitor keeps tracking until the delay has run out.
                if (link.sar_tick) begin
                    if (q.step_cnt == 4'h1) begin
                        d.st = ST_CONVERT;
                        d.step_cnt = bit_clocks(eight); // RULE4
                    end else begin
                        d.step_cnt = q.step_cnt - 4'h1;
                    end
                end
            end
            ST_CONVERT: begin
                if (link.sar_tick) begin
                    if (q.step_cnt == 4'h1) begin
                        d.conv_done = 1'b1;
                        // Sums wrap at sixteen bits; 64 ten-bit samples cannot overflow.
                        if (q.in_burst || q.accum_en) begin
                            d.acc = q.acc + sample; // RULE8 RULE12 RULE18
                        end else begin
                            d.acc = sample; // RULE8
                        end
                        if (q.reps_left == 7'h01) begin
                            d.st = ST_IDLE;
                            d.burst_done = 1'b1;
                        end else begin
                            d.reps_left = q.reps_left - 7'h01;
                            // In delayed track mode each further conversion gets its own tracking delay.
                            if (delayed) begin
                                d.st = ST_TRACK; // RULE15
                                d.step_cnt = TRACK_CLKS;
                            end else begin
                                d.step_cnt = bit_clocks(eight);
                            end
                        end
                    end else begin
                        d.step_cnt = q.step_cnt - 4'h1;
                    end
                end
            end
            default: begin
                // The unused code recovers to idle.
                d.st = ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // Outside burst the divider sees every system clock.
    property p_src_sysclk;
        @(posedge clk_i) disable iff (rst_i)
        !burst_mode_enable_i |-> link.src_tick;
    endproperty
    a_src_sysclk: assert property (p_src_sysclk) else $error("Divider source not the system clock."); // RULE2

    // Normal track goes straight to conversion with the full bit count.
    property p_normal_track;
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_IDLE && conv_start_i && adc_enable_i && !delayed)
        |=> (q.st == ST_CONVERT) && (q.step_cnt == bit_clocks($past(eight)));
    endproperty
    a_normal_track: assert property (p_normal_track) else $error("Normal track did not convert at once."); // RULE5

    // Delayed track waits three conversion clocks before the conversion.
    property p_delayed_track;
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_IDLE && conv_start_i && (adc_enable_i || burst_mode_enable_i) && delayed)
        |=> (q.st == ST_TRACK) && (q.step_cnt == TRACK_CLKS);
    endproperty
    a_delayed_track: assert property (p_delayed_track) else $error("Delayed track count wrong."); // RULE6

    // Every entry into conversion carries the bit count of the chosen resolution.
    property p_bit_count;
        @(posedge clk_i) disable iff (rst_i)
        (q.st != ST_CONVERT) ##1 (q.st == ST_CONVERT) |-> (q.step_cnt == bit_clocks($past(eight)));
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("Conversion bit count wrong."); // RULE4

    // A repeated burst conversion in delayed mode passes through tracking first.
    property p_burst_retrack;
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_CONVERT && link.sar_tick && q.step_cnt == 4'h1 && q.reps_left != 7'h01 && delayed)
        |=> (q.st == ST_TRACK) && (q.step_cnt == TRACK_CLKS);
    endproperty
    a_burst_retrack: assert property (p_burst_retrack) else $error("No tracking between burst conversions."); // RULE15

    // Without accumulation outside burst, the result is the latest sample alone.
    property p_latest_only;
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_CONVERT && link.sar_tick && q.step_cnt == 4'h1 && !q.in_burst && !q.accum_en)
        |=> (q.acc == $past(sample));
    endproperty
    a_latest_only: assert property (p_latest_only) else $error("Latest result not stored."); // RULE8

    // The accumulator configuration reads with its top two bits low.
    property p_acc_cfg_read;
        @(posedge clk_i) disable iff (rst_i)
        (req && reg_hit(wb_adr_i, IDX_ACC_CFG)) |=> wb_ack_o && (wb_dat_o[7:6] == 2'b00);
    endproperty
    a_acc_cfg_read: assert property (p_acc_cfg_read) else $error("Write-only or reserved bit read high."); // RULE10

    // A low result byte write lands in the accumulator unless a conversion ends or a burst starts then.
    property p_low_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr && reg_hit(wb_adr_i, IDX_RES_LO) && !(q.st == ST_CONVERT && link.sar_tick && q.step_cnt == 4'h1)
            && !(q.st == ST_IDLE && conv_start_i && burst_mode_enable_i))
        |=> (q.acc[7:0] == $past(wb_dat_i[7:0]));
    endproperty
    a_low_write: assert property (p_low_write) else $error("Low result byte write lost."); // RULE16

    // A burst start loads the conversions left with the count for the repeat code.
    property p_burst_len;
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_IDLE && conv_start_i && burst_mode_enable_i)
        |=> (q.reps_left == rpt_to_count($past(q.rpt)));
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("Burst repeat count wrong."); // RULE12
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the converter configuration and accumulator block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adc_cfg_pkg::*;
    // Bench-driven inputs, each given a value at time zero.
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic burst = 1'b0, start = 1'b0, osc = 1'b0, osc_run = 1'b0;
    logic [9:0] adr = '0, res = '0, r;
    logic [31:0] dat = '0, rdat;
    logic ack, tick, cdone, bdone, eight, gain, trk, cnv;
    logic [4:0] d;
    logic [7:0] v;
    logic [15:0] acc;
    logic [7:0] exp_q[$]; // Expected read bytes, oldest first.
    int fail_count = 0, n_compared = 0, cyc_n = 0, ticks, dones, fr;
    always #2 clk_i = ~clk_i;
    // The oscillator is unrelated in phase and stands still while it is stopped.
    always #6.1 if (osc_run) osc = ~osc;
    adc_config_and_accumulator i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .burst_mode_enable_i(burst), .adc_enable_i(1'b1), .conv_start_i(start), .lp_osc_i(osc),
        .conv_result_i(res), .conversion_clock_o(tick), .tracking_o(trk), .converting_o(cnv),
        .eight_bit_select_o(eight), .gain_select_o(gain), .conv_done_o(cdone), .burst_done_o(bdone));
    // Compares one value and counts it; a mismatch is reported at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Read answers are matched against the oldest note; a hang is cut short by the cycle ceiling.
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (ack === 1'b1 && !we) begin
            chk(rdat, {24'h0, exp_q.pop_front()});
        end
        if (cyc_n == 20000) begin
            fail_count++;
            final_report();
        end
    end
    // One classic cycle; the request is held until ack is sampled, then released for a cycle.
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] b);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h0, b};
        if (!w) exp_q.push_back(b);
        // Only the cycle ceiling may end this wait, so a lost answer is counted as a mismatch.
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Both result bytes are read separately, since the pair is not latched.
    task automatic rd_res(input logic [15:0] x);
        wb(1'b0, IDX_RES_LO, x[7:0]);
        wb(1'b0, IDX_RES_HI, x[15:8]);
    endtask
    // Starts a sequence and counts ticks before the first finished conversion and all finished conversions.
    task automatic conv(input int gap, input int hold);
        int n, last;
        ticks = 0;
        dones = 0;
        n = 0;
        last = 0;
        @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        // With the source stopped no tick may appear, whatever the system clock does.
        if (hold > 0) begin
            repeat (hold) @(posedge clk_i) if (tick === 1'b1) ticks++;
            chk(ticks, 0);
            chk({trk, cnv}, 2'b01);
            osc_run = 1'b1;
        end
        // A done pulse is counted first, so a tick in its cycle belongs to the next phase.
        do begin
            @(posedge clk_i);
            n++;
            if (cdone === 1'b1) dones++;
            if (tick === 1'b1 && dones == 0) begin
                if (gap > 0 && ticks > 0) chk(n - last, gap);
                ticks++;
                last = n;
            end
        end while (bdone !== 1'b1);
        chk({trk, cnv}, 2'b10);
    endtask
    initial begin
        void'($urandom(49));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, IDX_CONV_CFG, 8'hF8);
        wb(1'b0, IDX_ACC_CFG, 8'h00);
        // A nonzero repeat code is only written while burst mode is selected.
        burst <= 1'b1;
        wb(1'b1, IDX_ACC_CFG, 8'hFF);
        wb(1'b0, IDX_ACC_CFG, 8'h3F);
        wb(1'b0, 8'h10, 8'h00);
        wb(1'b1, IDX_ACC_CFG, 8'h00);
        burst <= 1'b0;
        $display("test registers done");
        // Three runs with a random divider: gain with normal track, delayed track, and eight-bit.
        for (int k = 0; k < 3; k++) begin
            // Wanted conversion clock in MHz; the divider is rounded up so the clock stays at or below it.
            fr = 63 + int'($urandom % 188);
            d = 5'((250 + fr - 1) / fr - 1);
            v = {d, 3'(1 << k)};
            wb(1'b1, IDX_CONV_CFG, v);
            wb(1'b0, IDX_CONV_CFG, v);
            r = 10'($urandom);
            res <= r;
            #1 chk({eight, gain}, {v[2], v[0]});
            conv(int'(d) + 1, 0);
            chk(ticks, k == 1 ? 13 : k == 2 ? 8 : 10);
            rd_res(k == 2 ? {6'h0, r[9:8], 8'h00} : {6'h0, r});
        end
        $display("test timing done");
        // Two conversions summed, then every defined format code on the read path.
        wb(1'b1, IDX_CONV_CFG, 8'h00);
        wb(1'b1, IDX_ACC_CFG, 8'h40);
        wb(1'b1, IDX_RES_LO, 8'h00);
        wb(1'b1, IDX_RES_HI, 8'h00);
        acc = '0;
        repeat (2) begin
            r = 10'($urandom);
            res <= r;
            acc = acc + 16'(r);
            conv(1, 0);
        end
        for (int c = 0; c < 5; c++) begin
            wb(1'b1, IDX_ACC_CFG, 8'(8'h40 | (c << 3)));
            rd_res(c == 4 ? acc << 6 : acc >> c);
        end
        wb(1'b1, IDX_ACC_CFG, 8'h00);
        wb(1'b1, IDX_RES_LO, 8'h5A);
        rd_res({acc[15:8], 8'h5A});
        $display("test accumulate done");
        // Burst runs for repeat codes zero to five; the first starts with the oscillator stopped.
        burst <= 1'b1;
        osc_run = 1'b0;
        for (int c = 0; c < 6; c++) begin
            wb(1'b1, IDX_ACC_CFG, 8'(c));
            // From the second burst on, delayed tracking runs before every conversion.
            if (c == 1) wb(1'b1, IDX_CONV_CFG, 8'h02);
            r = 10'($urandom);
            res <= r;
            conv(0, c == 0 ? 30 : 0);
            chk(dones, c == 0 ? 1 : 1 << (c + 1));
            rd_res(16'(r) * 16'(c == 0 ? 1 : 1 << (c + 1)));
        end
        $display("test burst done");
        final_report();
    end
endmodule
`default_nettype wire
